// File: design/adcsr_pkg.sv
/*
 * Package for the serial converter readout block: widths, frame counts, carriers.
 * Assumes one system clock at 100 MHz; the bit clock arrives as a pin.
 */
package adcsr_pkg;
    localparam int unsigned RESULT_BITS = 12;
    localparam logic [4:0] EN_EDGE = 5'h02;
    localparam logic [4:0] NULL_EDGE = 5'h03;
    localparam logic [4:0] MSB_EDGE = 5'h04;
    localparam logic [4:0] LSB_EDGE = 5'h0f;
    localparam logic [11:0] RESULT_RST = 12'h000;
    localparam logic [3:0] TOP_BIT = 4'hb;

    typedef enum logic [2:0] {
        ADCSR_IDLE, ADCSR_WAIT, ADCSR_NULL, ADCSR_MSBF, ADCSR_LSBF, ADCSR_ZERO
    } adcsr_state_t;

    typedef struct packed {
        logic data;
        logic data_oe;
    } adcsr_dout_t;

    typedef struct packed {
        logic bias_on;
        logic comparator_on;
        logic ref_connected;
        logic sampling;
    } adcsr_power_t;
endpackage : adcsr_pkg

// File: design/adcsr_readout.sv
/*
 * Device-side readout logic of a 12-bit sampling converter: frame sequencing,
 * serial output, sampling window and power control.
 * Assumes the host drives select and the bit clock as asynchronous pins and
 * keeps the bit clock slow enough for 100 MHz oversampling.
 */
// What this block does
// - Select low powers the device; select high forces full shutdown.
// - Output enabled at second clock pulse after select falls, never earlier.
// - After enable, one null bit, then 12 result bits on falling edges.
// - Device changes data on falling edge; host samples on next rising edge.
// - External bit clock shifts data and paces the conversion.
// - Select high resets the sequence; next fall begins fresh exchange.
// - After conversion, bias and comparator off and reference released.
// - Post-conversion power-down happens even with select still low.
// - Continued clocking sends result LSB first, then zeros.
// - Analog input sampled 1.5 to 2.0 clock cycles at exchange start.
`timescale 1ns/1ns
module adcsr_readout (
    input wire logic clk,
    input wire logic srst,
    input wire logic select_or_powerdown_n,
    input wire logic conversion_bit_clock,
    input wire logic [11:0] comparator_result,
    output adcsr_pkg::adcsr_dout_t dout,
    output adcsr_pkg::adcsr_power_t power,
    output logic conv_done
);
    import adcsr_pkg::*;

    logic [1:0] sel_sync_q;
    logic [1:0] clk_sync_q;
    logic sel_n_q;
    logic bclk_q;
    logic fall;
    logic sel_fall;
    adcsr_state_t state_q;
    logic [4:0] edge_cnt_q;
    logic [3:0] bit_idx_q;
    logic [11:0] result_q;
    adcsr_dout_t dout_q;
    adcsr_power_t power_q;
    logic done_q;

    // Second falling edge after select: output enable and end of sampling
    function automatic logic at_enable_edge(input logic [4:0] cnt);
        return cnt + 5'h01 == EN_EDGE;
    endfunction : at_enable_edge

    // Only the second stage is read by logic
    always_ff @(posedge clk) begin
        if (srst) begin
            sel_sync_q <= 2'h3;
            clk_sync_q <= 2'h0;
        end else begin
            sel_sync_q <= {sel_sync_q[0], select_or_powerdown_n};
            clk_sync_q <= {clk_sync_q[0], conversion_bit_clock};
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            sel_n_q <= 1'b1;
            bclk_q <= 1'b0;
        end else begin
            sel_n_q <= sel_sync_q[1];
            bclk_q <= clk_sync_q[1];
        end
    end

    assign fall = bclk_q & ~clk_sync_q[1];
    assign sel_fall = sel_n_q & ~sel_sync_q[1];

    // Frame sequencer advanced by falling bit clock edges only
    always_ff @(posedge clk) begin
        if (srst || sel_sync_q[1]) begin
            state_q <= ADCSR_IDLE;
            edge_cnt_q <= 5'h00;
            bit_idx_q <= TOP_BIT;
        end else if (sel_fall) begin
            state_q <= ADCSR_WAIT;
            edge_cnt_q <= 5'h00;
            bit_idx_q <= TOP_BIT;
        end else if (fall && state_q != ADCSR_IDLE) begin
            edge_cnt_q <= (edge_cnt_q == 5'h1f) ? edge_cnt_q : edge_cnt_q + 5'h01;
            case (state_q)
                ADCSR_WAIT: begin
                    if (at_enable_edge(edge_cnt_q)) begin
                        state_q <= ADCSR_NULL;
                    end
                end
                ADCSR_NULL: begin
                    state_q <= ADCSR_MSBF;
                    bit_idx_q <= TOP_BIT;
                end
                ADCSR_MSBF: begin
                    if (bit_idx_q == 4'h0) begin
                        state_q <= ADCSR_LSBF;
                        bit_idx_q <= 4'h1;
                    end else begin
                        bit_idx_q <= bit_idx_q - 4'h1;
                    end
                end
                ADCSR_LSBF: begin
                    if (bit_idx_q == TOP_BIT) begin
                        state_q <= ADCSR_ZERO;
                    end else begin
                        bit_idx_q <= bit_idx_q + 4'h1;
                    end
                end
                default: begin
                    state_q <= state_q;
                end
            endcase
        end
    end

    // Result latched at the falling edge that leaves the null state and shows the MSB
    always_ff @(posedge clk) begin
        if (srst) begin
            result_q <= RESULT_RST;
        end else if (state_q == ADCSR_NULL && fall) begin
            result_q <= comparator_result;
        end
    end

    // Output pin: data changes only on a falling edge, or is cleared when select goes high
    always_ff @(posedge clk) begin
        if (srst || sel_sync_q[1]) begin
            dout_q <= '0;
        end else if (fall) begin
            case (state_q)
                ADCSR_WAIT: begin
                    dout_q.data_oe <= at_enable_edge(edge_cnt_q);
                    dout_q.data <= 1'b0;
                end
                ADCSR_NULL: begin
                    dout_q <= '{data: comparator_result[TOP_BIT], data_oe: 1'b1};
                end
                ADCSR_MSBF: begin
                    if (bit_idx_q == 4'h0) begin
                        dout_q.data <= result_q[1];
                    end else begin
                        dout_q.data <= result_q[bit_idx_q - 4'h1];
                    end
                end
                ADCSR_LSBF: begin
                    dout_q.data <= (bit_idx_q == TOP_BIT) ? 1'b0 : result_q[bit_idx_q + 4'h1];
                end
                default: begin
                    dout_q.data <= 1'b0;
                end
            endcase
        end
    end

    // Power follows select, and drops after conversion even with select low
    always_ff @(posedge clk) begin
        if (srst || sel_sync_q[1]) begin
            power_q <= '0;
            done_q <= 1'b0;
        end else begin
            done_q <= 1'b0;
            if (sel_fall) begin
                power_q <= '{bias_on: 1'b1, comparator_on: 1'b1, ref_connected: 1'b1,
                             sampling: 1'b1};
            end else if (fall && state_q == ADCSR_WAIT && at_enable_edge(edge_cnt_q)) begin
                power_q.sampling <= 1'b0;
            end else if (fall && state_q == ADCSR_MSBF && bit_idx_q == 4'h1) begin
                // The LSB is decided at the edge that shows it, so the converter stops there
                power_q <= '0;
                done_q <= 1'b1;
            end
        end
    end

    assign dout = dout_q;
    assign power = power_q;
    assign conv_done = done_q;

    property p_oe_off_when_deselected;
        @(posedge clk) disable iff (srst) sel_sync_q[1] |=> !dout_q.data_oe;
    endproperty
    a_oe_off_when_deselected: assert property (p_oe_off_when_deselected)
        else $error("output enabled while deselected");

    property p_no_early_enable;
        @(posedge clk) disable iff (srst) state_q == ADCSR_WAIT |-> !dout_q.data_oe;
    endproperty
    a_no_early_enable: assert property (p_no_early_enable)
        else $error("output enabled before second pulse");

    property p_power_off_deselected;
        @(posedge clk) disable iff (srst) sel_sync_q[1] |=> power_q == '0;
    endproperty
    a_power_off_deselected: assert property (p_power_off_deselected)
        else $error("power on while deselected");

    property p_data_on_fall_only;
        @(posedge clk) disable iff (srst)
            !fall && !sel_sync_q[1] && !sel_fall |=> $stable(dout_q.data);
    endproperty
    a_data_on_fall_only: assert property (p_data_on_fall_only)
        else $error("data changed without falling edge");

    property p_done_powers_down;
        @(posedge clk) disable iff (srst) done_q |-> power_q == '0 && !sel_n_q;
    endproperty
    a_done_powers_down: assert property (p_done_powers_down)
        else $error("conversion end without power-down");

    property p_lsb_powers_down;
        @(posedge clk) disable iff (srst)
            fall && state_q == ADCSR_MSBF && bit_idx_q == 4'h1 && !sel_sync_q[1]
            |=> done_q && power_q == '0;
    endproperty
    a_lsb_powers_down: assert property (p_lsb_powers_down)
        else $error("no power-down at the last result bit");

    property p_msb_then_lsb;
        @(posedge clk) disable iff (srst)
            state_q == ADCSR_MSBF && fall && bit_idx_q == 4'h0 && !sel_sync_q[1]
            |=> state_q == ADCSR_LSBF;
    endproperty
    a_msb_then_lsb: assert property (p_msb_then_lsb)
        else $error("no LSB-first repeat after result");

    property p_null_enables;
        @(posedge clk) disable iff (srst)
            state_q == ADCSR_NULL && !sel_sync_q[1] |-> dout_q.data_oe && !dout_q.data;
    endproperty
    a_null_enables: assert property (p_null_enables)
        else $error("null bit missing");

    property p_fall_starts;
        @(posedge clk) disable iff (srst)
            sel_fall && !sel_sync_q[1] |=> state_q == ADCSR_WAIT && power_q.sampling;
    endproperty
    a_fall_starts: assert property (p_fall_starts)
        else $error("select fall did not start exchange");
endmodule : adcsr_readout

// File: bench/adcsr_host.sv
/* Host controller model: drives select and the bit clock, samples dout on rises.
   Assumes frame() is called at a falling clk edge. */
`timescale 1ns/1ns
module adcsr_host (
    input wire logic clk,
    output logic sel_n,
    output logic bclk,
    input wire adcsr_pkg::adcsr_dout_t dout,
    input wire adcsr_pkg::adcsr_power_t power
);
    import adcsr_pkg::*;
    adcsr_dout_t d_seen [0:31];
    adcsr_power_t p_seen [0:31];
    initial begin
        sel_n = 1'b1;
        // Bit clock stands high outside frames
        bclk = 1'b1;
    end
    task automatic frame(input int n, input int h);
        sel_n = 1'b0;
        repeat (h) @(negedge clk);
        // Caller passes n of at least fourteen for a full exchange
        for (int k = 1; k <= n; k++) begin
            bclk = 1'b0;
            repeat (h) @(negedge clk);
            bclk = 1'b1;
            d_seen[k] = dout;
            p_seen[k] = power;
            repeat (h) @(negedge clk);
        end
        sel_n = 1'b1;
        repeat (h) @(negedge clk);
    endtask : frame
endmodule : adcsr_host

// File: bench/adcsr_readout_test.sv
/* Self-checking bench: random results and bit clock rates, long and aborted frames.
   Assumes the host model paces every frame. */
`timescale 1ns/1ns
module adcsr_readout_test;
    import adcsr_pkg::*;
    logic clk, srst, sel_n, bclk, conv_done;
    logic [11:0] result;
    adcsr_dout_t dout;
    adcsr_power_t power;
    int n_fail, cmp_count, n_done;
    adcsr_readout adcsr_readout_i (.clk(clk), .srst(srst), .select_or_powerdown_n(sel_n),
        .conversion_bit_clock(bclk), .comparator_result(result), .dout(dout),
        .power(power), .conv_done(conv_done));
    adcsr_host adcsr_host_i (.clk(clk), .sel_n(sel_n), .bclk(bclk), .dout(dout),
        .power(power));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) if (conv_done === 1'b1) n_done++;
    task automatic check(input logic [11:0] seen, input logic [11:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    function automatic logic [1:0] exp_dout(logic [11:0] r, int k);
        if (k >= 3 && k <= 14) return {r[14-k], 1'b1};
        if (k >= 15 && k <= 25) return {r[k-14], 1'b1};
        return 2'b01;
    endfunction : exp_dout
    function automatic logic [3:0] exp_pwr(int k);
        return (k == 1) ? 4'hf : (k < 14) ? 4'he : 4'h0;
    endfunction : exp_pwr
    task automatic run_frame(input int n, input logic [11:0] r);
        int h, d0;
        // Varying the bit clock rate shows the conversion follows it
        h = 8 + $urandom_range(12);
        result = r;
        d0 = n_done;
        adcsr_host_i.frame(n, h);
        for (int k = 1; k <= n; k++) begin
            if (k == 1) check({11'h0, adcsr_host_i.d_seen[k].data_oe}, 12'h0);
            else check({10'h0, adcsr_host_i.d_seen[k]}, {10'h0, exp_dout(r, k)});
            check({8'h0, adcsr_host_i.p_seen[k]}, {8'h0, exp_pwr(k)});
        end
        check(12'(n_done - d0), {11'h0, n >= 14});
        check({7'h0, dout.data_oe, power}, 12'h0);
        $display("frame of %0d falls done, result %h", n, r);
    endtask : run_frame
    task automatic stop_test;
        $display("comparisons %0d, mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : stop_test
    initial begin
        #400000;
        n_fail++;
        stop_test();
    end
    initial begin
        n_fail = 0;
        cmp_count = 0;
        n_done = 0;
        srst = 1'b1;
        result = 12'h000;
        void'($urandom(88));
        repeat (2) @(negedge clk);
        srst = 1'b0;
        check({5'h0, dout, power, conv_done}, 12'h0);
        run_frame(15, 12'hfff);
        run_frame(15, 12'h000);
        run_frame(28, 12'ha5c);
        // Abort in mid-conversion, then a fresh exchange must start clean
        run_frame(6, 12'($urandom));
        for (int i = 0; i < 4; i++) begin
            run_frame(15 + $urandom_range(13), 12'($urandom));
        end
        stop_test();
    end
endmodule : adcsr_readout_test
